// ==== inc/smsa_pkg.sv ====
// shared constants and types for the serial port core
package smsa_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CTRLH = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_BAUD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // serial_port_control_low fields
    localparam int B_ON = 15;
    localparam int B_SIDL = 13;
    localparam int B_DSDO = 12;
    localparam int B_WHI = 11;
    localparam int B_WLO = 10;
    localparam int B_SMP = 9;
    localparam int B_CKE = 8;
    localparam int B_SLAVE_SELECT_USE = 7;
    localparam int B_CKP = 6;
    localparam int B_MST = 5;
    localparam int B_DSDI = 4;
    localparam int B_DSCK = 3;
    localparam int B_REF = 2;
    localparam int B_FE = 1;
    localparam int B_FIFO = 0;
    // high control fields
    localparam int B_AUD = 15;
    localparam int B_FRM = 7;
    // status fields
    localparam int B_ROV = 6;
    localparam int B_RBE = 5;
    localparam int B_TBE = 3;
    localparam int B_TBF = 1;
    localparam int B_RBF = 0;
    // reset values and write masks
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
    localparam logic [15:0] CTRL_LOCK = 16'h0C05;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    // word lengths and fifo depths
    localparam logic [5:0] L8 = 6'h08;
    localparam logic [5:0] L16 = 6'h10;
    localparam logic [5:0] L24 = 6'h18;
    localparam logic [5:0] L32 = 6'h20;
    localparam logic [5:0] D1 = 6'h01;
    localparam logic [5:0] D8 = 6'h08;
    localparam logic [5:0] D16 = 6'h10;
    localparam logic [5:0] D32 = 6'h20;
    // pad pins, driven as one registered group
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic lrc_o;
        logic lrc_oe;
    } smsa_pins_t;
endpackage

// ==== verilog/smsa_fifo.sv ====
// word fifo with a run-time depth limit
`timescale 1ns/10ps
module smsa_fifo #(
    parameter int DW = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic [5:0] limit,
    input wire logic push,
    input wire logic [DW-1:0] din,
    input wire logic pop,
    output logic [DW-1:0] dout,
    output logic empty,
    output logic full
);
    logic [DW-1:0] mem [DEPTH];
    logic [4:0] wp_q, rp_q;
    logic [5:0] cnt_q;
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;
    // limit lets one array serve every width mode
    assign empty = cnt_q == 6'h00;
    assign full = cnt_q >= limit;
    assign dout = mem[rp_q];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 5'h00;
            rp_q <= 5'h00;
            cnt_q <= 6'h00;
        end else if (ce) begin
            if (clr) begin
                wp_q <= 5'h00;
                rp_q <= 5'h00;
                cnt_q <= 6'h00;
            end else begin
                wp_q <= wp_q + 5'(do_push);
                rp_q <= rp_q + 5'(do_pop);
                cnt_q <= cnt_q + 6'(do_push) - 6'(do_pop);
            end
        end
    end
    // storage carries no reset
    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wp_q] <= din;
        end
    end
endmodule

// ==== verilog/smsa_core.sv ====
// serial port core: apb registers, shift engine, audio clocks
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - master starts on buffer write; slave waits clock
// - slave select gates slave transfers when enabled
// - select high tri-states output, aborts word
// - aborted word kept and resent from start
// - no select: empty sets on shift load
// - with select: empty sets after full word
// - audio master clocks run while enabled
// - audio master starts fast, shifts even empty
// - audio slave sends zeros until left edge
// - armed audio slave receives, shifts continuously
// - enable off resets port, stops clocks
// - stop-in-idle halts during processor idle
// - pin-disable bits take pins from port
// - width field sets word size, fifo depth
// - audio width field sets data, channel size
// - master sample phase selectable; slave mid-bit
// - clock-edge bit picks output change edge
// - polarity bit sets serial clock idle level
// - master bit drives clock; framed ignores select
// - baud source select, writable only when off
// - frame edge bit places channel clock edge
// - buffer mode picks fifo or single buffer
// - audio implies framed, mid-bit, clock-edge bit clear
module smsa_core #(
    parameter int DW = 32,
    parameter int DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_idle,
    input wire logic ref_clk,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic ss_i,
    output smsa_pkg::smsa_pins_t pins
);
    logic [15:0] ctrl_q, baud_q, bcnt_q;
    logic [1:0] ctrlh_q;
    logic rov_q, busy_q, from_fifo_q, armed_q, lrc_q;
    logic [3:0] s1_q, s2_q, s3_q;
    logic [31:0] tx_sr_q, rx_sr_q;
    logic [5:0] bitcnt_q;
    logic [6:0] half_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    smsa_pkg::smsa_pins_t pins_q;

    // configuration decode
    wire on = ctrl_q[smsa_pkg::B_ON];
    wire halt = ctrl_q[smsa_pkg::B_SIDL] & cpu_idle;
    wire run = on & ~halt;
    wire aud = ctrlh_q[1];
    wire frm = ctrlh_q[0] | aud;
    wire mst = ctrl_q[smsa_pkg::B_MST];
    wire cpol = ctrl_q[smsa_pkg::B_CKP];
    wire cke = ctrl_q[smsa_pkg::B_CKE] & ~aud;
    wire smp_end = mst & ctrl_q[smsa_pkg::B_SMP] & ~aud;
    wire whi = ctrl_q[smsa_pkg::B_WHI];
    wire wlo = ctrl_q[smsa_pkg::B_WLO];
    wire fe = ctrl_q[smsa_pkg::B_FE];
    wire dsdi = ctrl_q[smsa_pkg::B_DSDI];
    wire ss_used = ~mst & ctrl_q[smsa_pkg::B_SLAVE_SELECT_USE] & ~frm;

    // word, channel and depth selection
    wire [5:0] len_n = whi ? smsa_pkg::L32 : (wlo ? smsa_pkg::L16 : smsa_pkg::L8);
    wire [5:0] len_a = (whi | wlo) ? smsa_pkg::L32 : smsa_pkg::L16;
    wire [5:0] dlen_a = whi ? (wlo ? smsa_pkg::L24 : smsa_pkg::L32) : smsa_pkg::L16;
    wire [5:0] clen = aud ? len_a : len_n;
    wire [5:0] dlen = aud ? dlen_a : len_n;
    wire [5:0] dep_n = whi ? smsa_pkg::D8 : (wlo ? smsa_pkg::D16 : smsa_pkg::D32);
    wire [5:0] limit = ctrl_q[smsa_pkg::B_FIFO] ? dep_n : smsa_pkg::D1;

    // synchronised pins: bit0 clock, bit1 data, bit2 select, bit3 ref
    wire sck_s = s2_q[0];
    wire din = dsdi ? 1'b0 : s2_q[1];
    wire ss_s = s2_q[2];
    wire ref_rise = s2_q[3] & ~s3_q[3];
    wire lead = (sck_s != cpol) & (s3_q[0] == cpol);
    wire trail = (sck_s == cpol) & (s3_q[0] != cpol);
    wire lrc_fall = s3_q[2] & ~ss_s;
    wire ss_abort = ss_used & ss_s & busy_q;

    // apb decode; one wait state so read data comes from a flop
    wire acc = psel & penable & pready_q;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire h_ctrl = paddr == smsa_pkg::OFS_CTRL;
    wire h_ctrlh = paddr == smsa_pkg::OFS_CTRLH;
    wire h_data = paddr == smsa_pkg::OFS_DATA;
    wire h_baud = paddr == smsa_pkg::OFS_BAUD;
    wire h_stat = paddr == smsa_pkg::OFS_STAT;
    wire mapped = h_ctrl | h_ctrlh | h_data | h_baud | h_stat;

    // fifos
    logic [31:0] tx_head, rx_head;
    logic tx_empty, tx_full, rx_empty, rx_full;
    wire tx_push = wr & h_data & on;
    wire rx_pop = rd & h_data;
    logic tx_pop, rx_push;
    logic [31:0] rx_word;

    // lock mode bits while the port runs
    wire [15:0] wmask = on ? (smsa_pkg::CTRL_WMASK & ~smsa_pkg::CTRL_LOCK)
                           : smsa_pkg::CTRL_WMASK;
    wire [15:0] ctrl_d = (ctrl_q & ~wmask) | (pwdata[15:0] & wmask);
    wire [1:0] ctrlh_d = {on ? aud : pwdata[smsa_pkg::B_AUD], pwdata[smsa_pkg::B_FRM]};
    wire [31:0] stat_w = {25'h0000000, rov_q, rx_empty, 1'b0, tx_empty, 1'b0,
                          tx_full, rx_full};
    wire [31:0] rdata = h_ctrl ? {16'h0000, ctrl_q} :
                        h_ctrlh ? {16'h0000, ctrlh_q[1], 7'h00, ctrlh_q[0], 7'h00} :
                        h_data ? rx_head :
                        h_baud ? {16'h0000, baud_q} :
                        h_stat ? stat_w : 32'h00000000;

    // baud generator: peripheral clock or ref clock edges
    wire src_tick = ctrl_q[smsa_pkg::B_REF] ? ref_rise : 1'b1;
    wire hp_tick = run & mst & src_tick & (bcnt_q == baud_q);

    // master half-period sequencing
    wire [6:0] h_n = half_q + 7'h01;
    wire [6:0] h_end = {clen, 1'b0};
    wire m_tick = hp_tick & busy_q;
    wire m_end = m_tick & (h_n == h_end);
    wire m_chg = m_tick & ~h_n[0] & ~m_end;
    wire m_smp = m_tick & (smp_end ? ~h_n[0] : h_n[0]);

    // slave edge events; output changes on the chosen edge
    wire s_en = run & ~mst & busy_q & ~ss_abort & (~aud | armed_q);
    wire s_chg = s_en & (cke ? trail : lead) & (bitcnt_q != 6'h00);
    wire s_smp = s_en & (cke ? lead : trail);
    wire do_shift = mst ? m_chg : s_chg;
    wire do_smp = mst ? m_smp : s_smp;
    wire w_done = mst ? m_end : (s_smp & (bitcnt_q == clen - 6'h01));

    // load: master on data, audio free-running, slave when idle, audio slave once armed
    wire m_load = run & mst & ((~busy_q & (aud | ~tx_empty)) | (m_end & aud));
    wire s_load = run & ~mst & ~busy_q & (~aud | armed_q) & ~(ss_used & ss_s);
    wire load = m_load | s_load;
    wire [31:0] tx_al = tx_empty ? 32'h00000000 : (tx_head << (6'h20 - dlen));
    wire [31:0] rx_nx = {rx_sr_q[30:0], din};

    // empty flag: pop at load unless select is in use
    assign tx_pop = (load & ~tx_empty & ~ss_used) |
                    (w_done & from_fifo_q & ss_used);
    assign rx_push = w_done & ~(aud & dsdi);
    // mid-bit master ends a half after its last sample: no extra shift then
    assign rx_word = (do_smp ? rx_nx : rx_sr_q) >> (clen - dlen);

    smsa_fifo #(.DW(DW), .DEPTH(DEPTH)) u_tx (
        .clk(pclk), .rst_n(presetn), .ce(pce), .clr(~on), .limit(limit),
        .push(tx_push), .din(pwdata), .pop(tx_pop), .dout(tx_head),
        .empty(tx_empty), .full(tx_full)
    );
    smsa_fifo #(.DW(DW), .DEPTH(DEPTH)) u_rx (
        .clk(pclk), .rst_n(presetn), .ce(pce), .clr(~on), .limit(limit),
        .push(rx_push), .din(rx_word), .pop(rx_pop), .dout(rx_head),
        .empty(rx_empty), .full(rx_full)
    );

    // channel clock turns one bit early unless frame edge set
    wire lrc_flip = aud & mst & m_tick &
                    (fe ? m_end : (h_n == h_end - 7'h02));

    // pad drive computed from state; registered below
    smsa_pkg::smsa_pins_t pins_d;
    always_comb begin
        pins_d.sck_o = (mst & busy_q) ? cpol ^ (cke ? half_q[0] : ~half_q[0]) : cpol;
        pins_d.sck_oe = on & mst & ~ctrl_q[smsa_pkg::B_DSCK];
        pins_d.sdo_o = (aud & ~mst & ~armed_q) ? 1'b0 : tx_sr_q[31];
        pins_d.sdo_oe = on & ~ctrl_q[smsa_pkg::B_DSDO] & ~(ss_used & ss_s);
        pins_d.lrc_o = lrc_q;
        pins_d.lrc_oe = on & aud & mst;
    end

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
        end else if (pce) begin
            s1_q <= {ref_clk, ss_i, sdi_i, sck_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // apb slave and software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            ctrl_q <= smsa_pkg::CTRL_RST;
            ctrlh_q <= 2'b00;
            baud_q <= smsa_pkg::BAUD_RST;
            rov_q <= 1'b0;
        end else if (pce) begin
            pready_q <= psel & penable & ~pready_q;
            if (psel & penable & ~pready_q) begin
                prdata_q <= rdata;
                pslverr_q <= ~mapped;
            end
            if (wr & h_ctrl) ctrl_q <= ctrl_d;
            if (wr & h_ctrlh) ctrlh_q <= ctrlh_d;
            if (wr & h_baud & ~on) baud_q <= pwdata[15:0];
            // overflow set beats a same-cycle clear
            if (rx_push & rx_full & on) begin
                rov_q <= 1'b1;
            end else if (wr & h_stat & pwdata[smsa_pkg::B_ROV]) begin
                rov_q <= 1'b0;
            end
        end
    end

    // baud counter and channel clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 16'h0000;
            lrc_q <= 1'b0;
        end else if (pce) begin
            if (!on) begin
                bcnt_q <= 16'h0000;
                lrc_q <= 1'b0;
            end else if (run & mst & ~busy_q) begin
                bcnt_q <= 16'h0000; // idle: first half bit of a word is full length
            end else if (run & mst & src_tick) begin
                bcnt_q <= hp_tick ? 16'h0000 : bcnt_q + 16'h0001;
                if (lrc_flip) lrc_q <= ~lrc_q;
            end
        end
    end

    // shift engine; disable acts as a synchronous reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            from_fifo_q <= 1'b0;
            armed_q <= 1'b0;
            tx_sr_q <= 32'h00000000;
            rx_sr_q <= 32'h00000000;
            bitcnt_q <= 6'h00;
            half_q <= 7'h00;
        end else if (pce) begin
            if (!on) begin
                busy_q <= 1'b0;
                armed_q <= 1'b0;
                tx_sr_q <= 32'h00000000;
                bitcnt_q <= 6'h00;
                half_q <= 7'h00;
            end else if (ss_abort) begin
                busy_q <= 1'b0;
                bitcnt_q <= 6'h00;
            end else if (run) begin
                if (aud & ~mst & lrc_fall) armed_q <= 1'b1;
                if (load) begin
                    busy_q <= 1'b1;
                    from_fifo_q <= ~tx_empty;
                    tx_sr_q <= tx_al;
                    rx_sr_q <= 32'h00000000;
                    bitcnt_q <= 6'h00;
                    half_q <= 7'h00;
                end else begin
                    if (w_done) busy_q <= 1'b0;
                    if (do_shift) tx_sr_q <= {tx_sr_q[30:0], 1'b0};
                    if (do_smp) rx_sr_q <= rx_nx;
                    if (do_smp) bitcnt_q <= w_done ? 6'h00 : bitcnt_q + 6'h01;
                    if (m_tick) half_q <= h_n;
                end
            end
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= '0;
        end else if (pce) begin
            pins_q <= pins_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pins = pins_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ss_release: assert property (pce & ss_used & ss_s & on |=> !pins_q.sdo_oe)
        else $error("select high but output still driven");
    a_abort_keep: assert property (pce & ss_abort & ~tx_empty |=> !tx_empty)
        else $error("aborted word lost from holding buffer");
    a_load_clear: assert property (pce & tx_push & ~tx_full |=> !tx_empty)
        else $error("empty flag stayed set after buffer load");
    a_master_start: assert property (pce & run & mst & ~busy_q & ~tx_empty & ~aud
        |=> busy_q)
        else $error("master did not start on queued word");
    a_audio_run: assert property (pce & run & mst & aud & ~busy_q |=> busy_q)
        else $error("audio master stalled");
    a_slave_zero: assert property (pce & aud & ~mst & ~armed_q & on |=> !pins_q.sdo_o)
        else $error("audio slave drove data before left edge");
    a_off_quiet: assert property (pce & ~on |=> !pins_q.sck_oe && !pins_q.lrc_oe && !busy_q)
        else $error("disabled port still active");
    a_idle_halt: assert property (pce & halt & on |=> $stable(tx_sr_q))
        else $error("engine moved during idle halt");
    a_clk_pin: assert property (pce & ctrl_q[smsa_pkg::B_DSCK] |=> !pins_q.sck_oe)
        else $error("clock pin driven while disabled");
    a_len_sel: assert property (~aud & whi |-> clen == smsa_pkg::L32 && dlen == clen)
        else $error("wrong word length");
    a_sck_idle: assert property (pce & mst & ~busy_q |=> pins_q.sck_o == $past(cpol))
        else $error("clock not at idle level");
    a_slave_noclk: assert property (pce & ~mst |=> !pins_q.sck_oe)
        else $error("slave drove serial clock");

    c_master_word: cover property (mst & ~aud & w_done);
    c_slave_abort: cover property (ss_abort);
    c_audio_arm: cover property (aud & ~mst & lrc_fall ##1 armed_q);
    c_overflow: cover property (rx_push & rx_full & on);
endmodule

// ==== test/smsa_peer_model.sv ====
// serial slave model that faces the port while it runs as clock master
`timescale 1ns/10ps
module smsa_peer_model (
    input wire logic sck,
    input wire logic sdo,
    input wire logic cpol,
    input wire logic arm,
    input wire logic [5:0] len,
    input wire logic [31:0] reply,
    output logic sdi,
    output logic [31:0] got
);
    int idx;
    // idle: nothing to send yet, line shows a released level
    initial begin
        sdi = 1'b1;
        got = 32'h0;
        idx = -1;
    end
    // a new word starts with the msb of the reply
    always @(posedge arm) begin
        idx = int'(len) - 1;
        got = 32'h0;
    end
    // lead edge presents a bit, trail edge samples the port's output
    always @(sck) begin
        if (sck !== cpol && idx >= 0) begin
            sdi = reply[idx];
            idx--;
        end else if (sck === cpol) begin
            got = {got[30:0], sdo};
            // word over: released line toggles so a stale bit never passes
            if (idx < 0) begin
                sdi = ~sdi;
            end
        end
    end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the serial port core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module tb_top;
    localparam logic [7:0] a_ctrl = smsa_pkg::OFS_CTRL;
    localparam logic [7:0] a_ctrlh = smsa_pkg::OFS_CTRLH;
    localparam logic [7:0] a_data = smsa_pkg::OFS_DATA;
    localparam logic [7:0] a_baud = smsa_pkg::OFS_BAUD;
    localparam logic [7:0] a_stat = smsa_pkg::OFS_STAT;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_idle, ref_clk;
    logic b_sck, b_sdi, b_ss, arm, slv, cpol, sck_w, sdi_w, sdi_p, err, lv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, got, reply, peer_got;
    logic [5:0] len;
    smsa_pkg::smsa_pins_t pins;
    int mismatches, checks_done, n;
    // wire levels: clock from whoever drives it, data from the active far side
    assign sck_w = pins.sck_oe ? pins.sck_o : b_sck;
    assign sdi_w = slv ? b_sdi : sdi_p;
    smsa_core smsa_core_i (
        .pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .ref_clk(ref_clk),
        .sck_i(sck_w), .sdi_i(sdi_w), .ss_i(b_ss), .pins(pins)
    );
    smsa_peer_model smsa_peer_model_i (
        .sck(sck_w), .sdo(pins.sdo_o), .cpol(cpol), .arm(arm), .len(len),
        .reply(reply), .sdi(sdi_p), .got(peer_got)
    );
    // clocks: reference clock unrelated in phase to pclk
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        ref_clk = 1'b0;
        forever #41 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under a tenth of this
    initial begin
        #500000;
        `CHK("watchdog", 1'b1, 1'b0)
        final_report();
    end
    // one bus transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    // settings go in with the module off, then it is switched on
    task automatic cfg(input logic [15:0] c);
        apb(1'b1, a_ctrl, {16'h0, c & 16'h7FFF});
        apb(1'b1, a_ctrl, {16'h0, c | 16'h8000});
        cpol = c[smsa_pkg::B_CKP];
    endtask
    // poll status until a received word is waiting
    task automatic waitrx;
        n = 0;
        do begin
            apb(1'b0, a_stat, 32'h0);
            n++;
        end while (rd[smsa_pkg::B_RBE] !== 1'b0 && n < 200);
        `CHK("rx arrived", 1'b0, rd[smsa_pkg::B_RBE])
    endtask
    // master word against the peer; rx data is right aligned
    task automatic mxfer(input logic [31:0] w, input logic [5:0] l);
        logic [31:0] m;
        m = (l == 6'h20) ? 32'hFFFFFFFF : ((32'h1 << l) - 32'h1);
        len = l;
        reply = ~w;
        arm = 1'b1;
        apb(1'b1, a_data, w);
        waitrx();
        arm = 1'b0;
        `CHK("peer word", w & m, peer_got & m)
        rdc(a_data, reply & m, "rx word");
        rdc(a_stat, 32'h28, "status idle");
    endtask
    // bench as external master, 125 ns clock, select dropped after nb bits
    task automatic sxfer(input logic [7:0] w, input int nb);
        got = 32'h0;
        #3;
        b_ss = 1'b0;
        #200;
        for (int i = 7; i > 7 - nb; i--) begin
            b_sck = 1'b1;
            b_sdi = w[i];
            #62.5;
            b_sck = 1'b0;
            got = {got[30:0], pins.sdo_o};
            #62.5;
        end
        b_ss = 1'b1;
        b_sdi = ~b_sdi;
        #200;
        @(posedge pclk);
    endtask
    // main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        cpu_idle = 1'b0;
        b_sck = 1'b0;
        b_sdi = 1'b1;
        b_ss = 1'b1;
        arm = 1'b0;
        slv = 1'b0;
        cpol = 1'b0;
        len = 6'h08;
        reply = 32'h0;
        mismatches = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, an unmapped place, baud divider
        rdc(a_ctrl, 32'h0, "ctrl reset");
        rdc(a_stat, 32'h28, "stat reset");
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, a_baud, 32'h4);
        rdc(a_baud, 32'h4, "baud");
        // every word width; last one with cpu idle while stop-in-idle is clear
        for (int i = 0; i < 3; i++) begin
            cfg(16'h0020 | (16'(i) << 10));
            cpu_idle <= (i == 2);
            mxfer(32'hC3A55A3C >> (32 - (8 << i)), 6'(8 << i));
        end
        cpu_idle <= 1'b0;
        // inverted clock polarity, then locked fields while on
        cfg(16'h0060);
        repeat (2) @(posedge pclk);
        `CHK("idle high", 1'b1, pins.sck_o)
        `CHK("sck driven", 1'b1, pins.sck_oe)
        mxfer(32'h5A, 6'h08);
        apb(1'b1, a_ctrl, 32'h8C65);
        rdc(a_ctrl, 32'h8060, "locked bits");
        apb(1'b1, a_baud, 32'h9);
        rdc(a_baud, 32'h4, "baud locked");
        // pins taken away from the port function
        cfg(16'h1028);
        apb(1'b1, a_data, 32'h33);
        repeat (20) @(posedge pclk);
        `CHK("sdo given up", 1'b0, pins.sdo_oe)
        `CHK("sck given up", 1'b0, pins.sck_oe)
        waitrx();
        apb(1'b0, a_data, 32'h0);
        // stop-in-idle set: nothing moves while the cpu idles
        cfg(16'h2020);
        cpu_idle <= 1'b1;
        apb(1'b1, a_data, 32'h7E);
        repeat (200) @(posedge pclk);
        rdc(a_stat, 32'h22, "halted");
        cpu_idle <= 1'b0;
        waitrx();
        apb(1'b0, a_data, 32'h0);
        // module off: writes dropped, pins released
        apb(1'b1, a_ctrl, 32'h0020);
        apb(1'b1, a_data, 32'h11);
        rdc(a_stat, 32'h28, "off drops");
        `CHK("off sck", 1'b0, pins.sck_oe)
        // slave with select: abort mid-word, then resend whole
        slv = 1'b1;
        cfg(16'h0080);
        apb(1'b1, a_data, 32'h96);
        rdc(a_stat, 32'h22, "tx loaded");
        sxfer(8'h3C, 3);
        `CHK("sdo floated", 1'b0, pins.sdo_oe)
        rdc(a_stat, 32'h22, "abort kept");
        sxfer(8'h3C, 8);
        `CHK("resent", 32'h96, got & 32'hFF)
        rdc(a_stat, 32'h09, "slave done");
        rdc(a_data, 32'h3C, "slave rx");
        // audio master: clocks start quickly and run with no data
        slv = 1'b0;
        apb(1'b1, a_ctrl, 32'h0020);
        apb(1'b1, a_ctrlh, 32'h8000);
        apb(1'b1, a_ctrl, 32'h8020);
        n = 1;
        while (pins.sck_o === 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        `CHK("sck start", 1'b1, n <= 12)
        `CHK("lrc driven", 1'b1, pins.lrc_oe)
        lv = pins.lrc_o;
        n = 0;
        repeat (400) begin
            @(posedge pclk);
            n += (pins.lrc_o !== lv);
            lv = pins.lrc_o;
        end
        `CHK("lrc running", 1'b1, n >= 2)
        final_report();
    end
endmodule
